// >>> design/arfd_params.svh
// Timing, code and pipeline constants for the range-flag output path
// Assumes inclusion by the package, the design modules and the testbench files
`ifndef ARFD_PARAMS_SVH
`define ARFD_PARAMS_SVH

// Core clock and conversion rate
`define ARFD_CLK_PERIOD_NS 20
`define ARFD_SAMPLE_PERIOD_NS 100
`define ARFD_SAMPLE_CYCLES (`ARFD_SAMPLE_PERIOD_NS / `ARFD_CLK_PERIOD_NS)
// Least high time of the sample clock, rounded up to whole cycles
`define ARFD_CLK_HIGH_NS 45
`define ARFD_HIGH_CYCLES ((`ARFD_CLK_HIGH_NS + `ARFD_CLK_PERIOD_NS - 1) / `ARFD_CLK_PERIOD_NS)

// Output code layout
`define ARFD_CODE_W 14
`define ARFD_IN_W 16
`define ARFD_MIDSCALE 16'sh2000
`define ARFD_NEG_FULL_SCALE (-16'sh2000)
`define ARFD_POS_LAST_CODE 16'sh1fff
`define ARFD_CODE_ZERO 14'h0000
`define ARFD_CODE_ONES 14'h3fff

// Pipeline latency in conversions between hold and output update
`define ARFD_PIPE_DEPTH 3

`endif

// >>> design/arfd_pkg.sv
// Types shared by the range-flag output path
// Assumes arfd_params.svh is on the include path
`include "arfd_params.svh"

package arfd_pkg;

	// One converted sample: code and its out-of-range flag travel together
	typedef struct packed {
		logic out_of_range_flag; // High when input beyond range
		logic [`ARFD_CODE_W-1:0] code; // Straight binary code
	} arfd_sample_s;

	// Sample clock phase sequencer
	typedef enum logic [1:0] {
		ARFD_IDLE,
		ARFD_HIGH,
		ARFD_LOW
	} arfd_phase_e;

	typedef logic [3:0] arfd_count_t;

endpackage

// >>> design/arfd_delay_line.sv
// Fixed-depth delay line for converted samples
// Assumes one clock, synchronous reset, advance strobe from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "arfd_params.svh"

module arfd_delay_line (
	input wire logic i_clk, // Core clock
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_advance, // One-cycle shift enable
	input wire arfd_pkg::arfd_sample_s i_sample, // Sample entering the pipe
	output arfd_pkg::arfd_sample_s o_sample // Registered sample leaving the pipe
);
	import arfd_pkg::*;

	arfd_sample_s stage [`ARFD_PIPE_DEPTH]; // Pipe stages
	arfd_sample_s next_stage [`ARFD_PIPE_DEPTH]; // Next stage contents

	// Each stage moves by one on the advance strobe, flag and code as one word
	genvar g;
	generate
		for (g = 0; g < `ARFD_PIPE_DEPTH; g++) begin : g_stage
			always_comb begin
				next_stage[g] = stage[g];
				if (i_advance) begin
					next_stage[g] = (g == 0) ? i_sample : stage[(g == 0) ? 0 : g - 1];
				end
			end
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					stage[g] <= '0;
				end else begin
					stage[g] <= next_stage[g];
				end
			end
		end
	endgenerate

	// Read data straight from the last register
	assign o_sample = stage[`ARFD_PIPE_DEPTH-1];

endmodule
`default_nettype wire

// >>> design/arfd_range_flag.sv
// Output logic of a pipelined 14-bit converter: code and out-of-range flag
// Assumes the analog front end delivers a signed level in LSBs about midscale
// Operation
// - Flag updates with its sample's data word
// - Flag low when input within range
// - Flag high when input above or below range
// - Flag holds high until in-range conversion output
// - Timing derived from both sample clock edges
// - Straight binary, clamped at both full scales
`timescale 1ns/1ps
`default_nettype none
`include "arfd_params.svh"

module arfd_range_flag (
	input wire logic i_clk, // Core clock, 50 MHz
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_run, // Conversion enable, from a pin
	input wire logic signed [`ARFD_IN_W-1:0] i_analog, // Input level in LSBs, from pins
	output logic o_sample_clk, // Sample clock seen by the pipeline
	output logic [`ARFD_CODE_W-1:0] o_data, // Straight binary output word
	output logic o_out_of_range_flag, // Out-of-range flag
	output logic o_data_update // Pulse on each data and flag load, changed or not
);
	import arfd_pkg::*;

	localparam arfd_count_t SAMPLE_CYCLES = arfd_count_t'(`ARFD_SAMPLE_CYCLES);
	localparam arfd_count_t HIGH_CYCLES = arfd_count_t'(`ARFD_HIGH_CYCLES);

	// Pin synchronisers, first stage read only by the second
	logic run_meta; // First stage of run
	logic run_sync; // Usable run level
	logic signed [`ARFD_IN_W-1:0] analog_meta; // First stage of input
	logic signed [`ARFD_IN_W-1:0] analog_sync; // Usable input level

	// Phase sequencer state
	arfd_phase_e phase; // Current half of the sample clock
	arfd_phase_e next_phase;
	arfd_count_t count; // Cycles spent in this half
	arfd_count_t next_count;
	logic rise_evt; // Rising edge of the sample clock
	logic fall_evt; // Falling edge of the sample clock

	// Hold and quantiser state
	logic signed [`ARFD_IN_W-1:0] held; // Level held on the rising edge
	logic signed [`ARFD_IN_W-1:0] next_held;
	arfd_sample_s quant; // Quantised sample awaiting the pipe
	arfd_sample_s next_quant;
	logic quant_valid; // Quantiser holds a fresh sample
	logic next_quant_valid;
	arfd_sample_s pipe_out; // Sample leaving the pipe

	// Output registers
	logic sample_clk;
	logic next_sample_clk;
	logic [`ARFD_CODE_W-1:0] data;
	logic [`ARFD_CODE_W-1:0] next_data;
	logic flag;
	logic next_flag;
	logic update;
	logic next_update;
	logic [`ARFD_PIPE_DEPTH-1:0] fill; // Marks pipe stages holding real samples
	logic [`ARFD_PIPE_DEPTH-1:0] next_fill;

	// Two flops on every pin input
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			run_meta <= 1'b0;
			run_sync <= 1'b0;
			analog_meta <= '0;
			analog_sync <= '0;
		end else begin
			run_meta <= i_run;
			run_sync <= run_meta;
			analog_meta <= i_analog;
			analog_sync <= analog_meta;
		end
	end

	// Sample clock phases; both edges drive internal steps
	always_comb begin
		next_phase = phase;
		next_count = count + 4'h1;
		rise_evt = 1'b0;
		fall_evt = 1'b0;
		case (phase)
			ARFD_IDLE: begin
				next_count = 4'h0;
				if (run_sync) begin
					next_phase = ARFD_HIGH;
					rise_evt = 1'b1;
				end
			end
			ARFD_HIGH: begin
				if (count == HIGH_CYCLES - 4'h1) begin
					next_phase = ARFD_LOW;
					next_count = 4'h0;
					fall_evt = 1'b1;
				end
			end
			ARFD_LOW: begin
				if (count == SAMPLE_CYCLES - HIGH_CYCLES - 4'h1) begin
					next_count = 4'h0;
					if (run_sync) begin
						next_phase = ARFD_HIGH;
						rise_evt = 1'b1;
					end else begin
						next_phase = ARFD_IDLE;
					end
				end
			end
			default: begin
				next_phase = ARFD_IDLE;
				next_count = 4'h0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			phase <= ARFD_IDLE;
			count <= 4'h0;
		end else begin
			phase <= next_phase;
			count <= next_count;
		end
	end

	// Hold on the rising edge, quantise on the falling edge
	always_comb begin
		next_held = held;
		next_quant = quant;
		next_quant_valid = quant_valid;
		if (rise_evt) begin
			next_held = analog_sync;
			next_quant_valid = 1'b0; // Consumed by the pipe on this edge
		end
		if (fall_evt) begin
			next_quant_valid = 1'b1;
			if (held < `ARFD_NEG_FULL_SCALE) begin
				next_quant.code = `ARFD_CODE_ZERO;
				next_quant.out_of_range_flag = 1'b1;
			end else if (held > `ARFD_POS_LAST_CODE) begin
				next_quant.code = `ARFD_CODE_ONES;
				next_quant.out_of_range_flag = 1'b1;
			end else begin
				// Offset by midscale: zero input gives only the top bit set
				next_quant.code = `ARFD_CODE_W'(held + `ARFD_MIDSCALE);
				next_quant.out_of_range_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			held <= '0;
			quant <= '0;
			quant_valid <= 1'b0;
		end else begin
			held <= next_held;
			quant <= next_quant;
			quant_valid <= next_quant_valid;
		end
	end

	// Latency stages; code and flag share one word so they cannot skew
	arfd_delay_line u_pipe (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_advance(rise_evt),
		.i_sample(quant),
		.o_sample(pipe_out)
	);

	// Output update on the rising edge after the pipe has advanced.
	// The flag changes only here, so a high flag is held until a later
	// in-range conversion reaches the output.
	always_comb begin
		next_sample_clk = (next_phase == ARFD_HIGH);
		next_data = data;
		next_flag = flag;
		next_update = 1'b0;
		next_fill = fill;
		if (rise_evt) begin
			next_fill = {fill[`ARFD_PIPE_DEPTH-2:0], quant_valid};
		end
		// Pipe output is read one cycle after it shifted.
		// The mark of the last stage gates it; one place further would drop a sample.
		if (phase == ARFD_HIGH && count == 4'h0 && fill[`ARFD_PIPE_DEPTH-1]) begin
			next_data = pipe_out.code;
			next_flag = pipe_out.out_of_range_flag;
			next_update = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sample_clk <= 1'b0;
			data <= '0;
			flag <= 1'b0;
			update <= 1'b0;
			fill <= '0;
		end else begin
			sample_clk <= next_sample_clk;
			data <= next_data;
			flag <= next_flag;
			update <= next_update;
			fill <= next_fill;
		end
	end

	// Outputs straight from flops
	assign o_sample_clk = sample_clk;
	assign o_data = data;
	assign o_out_of_range_flag = flag;
	assign o_data_update = update;

endmodule
`default_nettype wire

// >>> tb/arfd_range_flag_chk.sv
// Checker for the converter output path
// Assumes binding to arfd_range_flag, one clock
`timescale 1ns/1ps
`default_nettype none
`include "arfd_params.svh"
module arfd_range_flag_chk (
	input wire logic i_clk, // Clock
	input wire logic i_srst, // Reset
	input wire logic i_run, // Run
	input wire logic signed [`ARFD_IN_W-1:0] i_analog, // Level
	input wire logic o_sample_clk, // Sample clock
	input wire logic [`ARFD_CODE_W-1:0] o_data, // Word
	input wire logic o_out_of_range_flag, // Flag
	input wire logic o_data_update // Update pulse
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// Word and flag move only on the update pulse
	flag_on_upd_a: assert property ($changed(o_out_of_range_flag) |-> o_data_update)
		else $error("flag moved alone");
	data_on_upd_a: assert property ($changed(o_data) |-> o_data_update)
		else $error("data moved alone");
	upd_pulse_a: assert property (o_data_update |=> !o_data_update)
		else $error("update too long");
	// Flagged samples are clamped to a full-scale code
	flag_clamp_a: assert property (o_out_of_range_flag |-> o_data == 14'h0000 || o_data == 14'h3fff)
		else $error("flagged code not clamped");
	// Both clock edges pace the pipeline, so both phases need their width
	clk_high_a: assert property ($rose(o_sample_clk) |-> o_sample_clk[*3] ##1 !o_sample_clk)
		else $error("sample clock high phase");
	clk_low_a: assert property ($fell(o_sample_clk) |-> !o_sample_clk[*2])
		else $error("sample clock low phase");
	cover property (o_data_update && o_out_of_range_flag && o_data[13]);
	cover property (o_data_update && o_out_of_range_flag && !o_data[13]);
	cover property (o_data_update && !o_out_of_range_flag);
endmodule
bind arfd_range_flag arfd_range_flag_chk u_chk (.i_clk, .i_srst, .i_run, .i_analog,
	.o_sample_clk, .o_data, .o_out_of_range_flag, .o_data_update);
`default_nettype wire

// >>> tb/arfd_rx_model.sv
// Receiver model: captures word and flag, classes range, signed view
// Assumes update pulse and word from the converter, same clock
`timescale 1ns/1ps
`default_nettype none
`include "arfd_params.svh"
module arfd_rx_model (
	input wire logic i_clk, // Clock
	input wire logic i_srst, // Reset
	input wire logic i_update, // New word present
	input wire arfd_pkg::arfd_sample_s i_sample, // Word and flag
	output arfd_pkg::arfd_sample_s o_sample, // Captured pair
	output logic [1:0] o_range, // 0 in, 1 under, 2 over
	output logic [`ARFD_CODE_W-1:0] o_signed // Twos complement
);
	import arfd_pkg::*;
	arfd_sample_s next_sample; // Pair, next
	logic [1:0] next_range; // Class, next
	// All three taken on one edge so they never skew
	always_comb begin
		next_sample = o_sample;
		next_range = o_range;
		if (i_update) begin
			next_sample = i_sample;
			next_range = !i_sample.out_of_range_flag ? 2'h0 : (i_sample.code[13] ? 2'h2 : 2'h1);
		end
	end
	always_ff @(posedge i_clk) begin
		o_sample <= i_srst ? '0 : next_sample;
		o_range <= i_srst ? 2'h0 : next_range;
	end
	// Only the top bit flips
	assign o_signed = {~o_sample.code[13], o_sample.code[12:0]};
endmodule
`default_nettype wire

// >>> tb/arfd_range_flag_tb_top.sv
// Testbench for the converter output path
// Assumes the design, checker and receiver model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "arfd_params.svh"
module arfd_range_flag_tb_top;
	import arfd_pkg::*;
	logic i_clk, i_srst, i_run; // Drives
	logic signed [`ARFD_IN_W-1:0] i_analog; // Level
	logic o_sample_clk, o_out_of_range_flag, o_data_update; // Outputs
	logic [`ARFD_CODE_W-1:0] o_data, rx_signed; // Words
	arfd_sample_s rx_sample; // Captured pair
	logic [1:0] rx_range; // Class
	int bad_count = 0, num_checks = 0, cycles = 0; // Tallies
	arfd_range_flag u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_run(i_run), .i_analog(i_analog),
		.o_sample_clk(o_sample_clk), .o_data(o_data),
		.o_out_of_range_flag(o_out_of_range_flag), .o_data_update(o_data_update));
	arfd_rx_model u_rx (.i_clk(i_clk), .i_srst(i_srst), .i_update(o_data_update),
		.i_sample({o_out_of_range_flag, o_data}), .o_sample(rx_sample), .o_range(rx_range),
		.o_signed(rx_signed));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Next update, bounded
	task automatic wait_upd();
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_data_update !== 1'b1 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		if (n == 40) bad_count++;
	endtask
	// Hold a level long enough to flush synchronisers and pipe
	task automatic settle(input logic [15:0] lvl);
		i_analog = lvl;
		repeat (7) wait_upd();
	endtask
	// Both full-scale edges just inside, midscale, just outside on top and well outside at the bottom
	task automatic t_codes();
		logic [15:0] lvl [5] = '{16'hdcd8, 16'he000, 16'h0000, 16'h1fff, 16'h2000};
		logic [13:0] cod [5] = '{14'h0000, 14'h0000, 14'h2000, 14'h3fff, 14'h3fff};
		logic flg [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		logic [1:0] rng [5] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h2};
		logic [13:0] sgn [5] = '{14'h2000, 14'h2000, 14'h0000, 14'h1fff, 14'h1fff};
		for (int k = 0; k < 5; k++) begin
			settle(lvl[k]);
			check(16'(o_data), 16'(cod[k]));
			check(16'(o_out_of_range_flag), 16'(flg[k]));
			@(negedge i_clk);
			check(16'(rx_range), 16'(rng[k]));
			check(16'(rx_signed), 16'(sgn[k]));
			check(16'(rx_sample), 16'({flg[k], cod[k]}));
		end
	endtask
	// Sample clock shape: high and low widths in core cycles
	task automatic t_clk();
		int hi, lo;
		hi = 0;
		lo = 0;
		while (o_sample_clk === 1'b1 && hi < 10) begin
			hi++;
			@(negedge i_clk);
		end
		while (o_sample_clk === 1'b0 && lo < 10) begin
			lo++;
			@(negedge i_clk);
		end
		hi = 0;
		lo = 0;
		while (o_sample_clk === 1'b1 && hi < 10) begin
			hi++;
			@(negedge i_clk);
		end
		while (o_sample_clk === 1'b0 && lo < 10) begin
			lo++;
			@(negedge i_clk);
		end
		check(16'(hi), 16'(`ARFD_HIGH_CYCLES));
		check(16'(lo), 16'(`ARFD_SAMPLE_CYCLES - `ARFD_HIGH_CYCLES));
	endtask
	// Flag holds until the first in-range word comes out
	task automatic t_recover();
		int n;
		settle(16'h2100);
		i_analog = 16'h0064;
		n = 0;
		wait_upd();
		while (o_data !== 14'h2064 && n < 10) begin
			check(16'(o_out_of_range_flag), 16'h0001);
			wait_upd();
			n++;
		end
		check(16'(o_data), 16'h2064);
		check(16'(o_out_of_range_flag), 16'h0000);
	endtask
	// Stopped converter must not update
	task automatic t_idle();
		int ups;
		ups = 0;
		i_run = 1'b0;
		repeat (12) @(negedge i_clk);
		repeat (20) begin
			@(negedge i_clk);
			if (o_data_update === 1'b1) ups++;
		end
		check(ups[15:0], 16'h0000);
		check(16'(o_data), 16'h2064);
		check(16'(o_sample_clk), 16'h0000);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Hang guard, well past the expected run
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		i_srst = 1'b1;
		i_run = 1'b0;
		i_analog = 16'h0000;
		repeat (8) @(negedge i_clk);
		i_srst = 1'b0;
		i_run = 1'b1;
		t_codes();
		t_clk();
		t_recover();
		t_idle();
		conclude();
	end
endmodule
`default_nettype wire
